// file: tw_timer16.sv
// 16-bit timer/counter: waveform modes, compare outputs, capture, clock select
`timescale 1ns/1ps
`include "tw_defs.svh"

// Overview of operation
// - Action fields at 7:6 and 5:4; nonzero takes pin, drives only if direction set.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clears on match, sets at BOTTOM; 11 the inverse.
// - PWM value 01: off unless top mode bit set; then A toggles, B reserved.
// - Dual slope: 10 clears on up match, sets on down match; 11 reverse.
// - Fast PWM with compare equal TOP and high action bit: only BOTTOM action.
// - Mode is control A bits 1:0 plus control B bits 4:3.
// - Modes 0, 4, 12: TOP max, compare A, capture; immediate update; overflow at MAX.
// - Phase modes 1-3 fixed TOP, 10-11 register TOP; update TOP, overflow BOTTOM.
// - Modes 8 and 9 register TOP; update and overflow at BOTTOM.
// - Filter bit makes capture need four equal samples, delaying it five cycles.
// - Edge bit: zero captures falling edge, one captures rising edge.
// - Selected edge copies counter to capture register and sets capture flag.
// - Capture register as TOP disconnects capture input entirely.
// - Clock select: stop, divide 1/8/64/256/1024, external falling or rising.
// - External pin edges count even when the pin is an output.
// - Control B bit 5 reads zero, writes ignored.
// - Low byte write loads temporary high byte and low byte together.
// - Force bit applies channel action as a match, only in non-PWM modes.
// - Force raises no flag, never clears counter, reads back zero.
module tw_timer16 #(
	parameter int CNT_W    = 16,
	parameter int PRESC_W  = 10
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         sys_rst,
	// CPU I/O register port
	input  wire logic [5:0]   io_addr,
	input  wire logic         io_wr,
	input  wire logic         io_rd,
	input  wire logic [7:0]   io_wdata,
	output logic      [7:0]   io_rdata,
	// Port direction bits of the two wave pins
	input  wire logic         dir_out_a,
	input  wire logic         dir_out_b,
	// Pins
	input  wire logic         capture_input_pin,
	input  wire logic         external_count_pin,
	output tw_pkg::tw_pin_t   wave_out_a,
	output tw_pkg::tw_pin_t   wave_out_b,
	// Event flags towards the interrupt unit
	output logic      [7:0]   event_flags
);

	// Elaboration-time refusal of widths the decode cannot serve
	if (CNT_W != 16 || PRESC_W != 10) begin : g_bad_width
		$error("tw_timer16: only a 16-bit counter with a 10-bit prescaler is supported");
	end

	// Registers
	logic [7:0]        output_action_mode_control;
	logic [7:0]        capture_mode_clock_control;
	logic [7:0]        flags;
	logic [7:0]        temp_high;
	logic [15:0]       counter_value;
	logic              count_up;
	logic [15:0]       compare_value_a;
	logic [15:0]       compare_value_b;
	logic [15:0]       cmp_buf_a;
	logic [15:0]       cmp_buf_b;
	logic [15:0]       capture_value_reg;
	logic              match_blocked;
	logic [PRESC_W-1:0] presc;
	logic [1:0]        ext_sync;
	logic              ext_prev;
	logic [1:0]        cap_sync;
	logic [3:0]        cap_hist;
	logic              cap_filt;
	logic              cap_prev;
	logic              level_a;
	logic              level_b;
	logic [7:0]        rdata;

	// Field decode
	wire [1:0] chan_a_output_action = output_action_mode_control[`TW_ACT_A_HI:`TW_ACT_A_LO];
	wire [1:0] chan_b_output_action = output_action_mode_control[`TW_ACT_B_HI:`TW_ACT_B_LO];
	wire [3:0] waveform_mode = {capture_mode_clock_control[`TW_WGM_HI_HI:`TW_WGM_HI_LO],
		output_action_mode_control[`TW_WGM_LO_HI:`TW_WGM_LO_LO]};
	wire       waveform_mode_top_bit  = waveform_mode[3];
	wire [2:0] count_clock_select     = capture_mode_clock_control[`TW_CS_HI:`TW_CS_LO];
	wire       capture_filter_enable  = capture_mode_clock_control[`TW_FILT_EN_BIT];
	wire       capture_edge_select    = capture_mode_clock_control[`TW_EDGE_SEL_BIT];

	tw_pkg::tw_mode_t mode;

	always_comb begin
		mode = '{tw_pkg::TW_K_NORMAL, tw_pkg::TW_T_MAX, tw_pkg::TW_U_IMM};
		case (waveform_mode)
			4'h0: mode = '{tw_pkg::TW_K_NORMAL, tw_pkg::TW_T_MAX,   tw_pkg::TW_U_IMM};
			4'h1: mode = '{tw_pkg::TW_K_PHASE,  tw_pkg::TW_T_8BIT,  tw_pkg::TW_U_TOP};
			4'h2: mode = '{tw_pkg::TW_K_PHASE,  tw_pkg::TW_T_9BIT,  tw_pkg::TW_U_TOP};
			4'h3: mode = '{tw_pkg::TW_K_PHASE,  tw_pkg::TW_T_10BIT, tw_pkg::TW_U_TOP};
			4'h4: mode = '{tw_pkg::TW_K_CTC,    tw_pkg::TW_T_CMPA,  tw_pkg::TW_U_IMM};
			4'h5: mode = '{tw_pkg::TW_K_FAST,   tw_pkg::TW_T_8BIT,  tw_pkg::TW_U_TOP};
			4'h6: mode = '{tw_pkg::TW_K_FAST,   tw_pkg::TW_T_9BIT,  tw_pkg::TW_U_TOP};
			4'h7: mode = '{tw_pkg::TW_K_FAST,   tw_pkg::TW_T_10BIT, tw_pkg::TW_U_TOP};
			4'h8: mode = '{tw_pkg::TW_K_PFC,    tw_pkg::TW_T_CAPV,  tw_pkg::TW_U_BOTTOM};
			4'h9: mode = '{tw_pkg::TW_K_PFC,    tw_pkg::TW_T_CMPA,  tw_pkg::TW_U_BOTTOM};
			4'hA: mode = '{tw_pkg::TW_K_PHASE,  tw_pkg::TW_T_CAPV,  tw_pkg::TW_U_TOP};
			4'hB: mode = '{tw_pkg::TW_K_PHASE,  tw_pkg::TW_T_CMPA,  tw_pkg::TW_U_TOP};
			4'hC: mode = '{tw_pkg::TW_K_CTC,    tw_pkg::TW_T_CAPV,  tw_pkg::TW_U_IMM};
			4'hD: mode = '{tw_pkg::TW_K_RSVD,   tw_pkg::TW_T_MAX,   tw_pkg::TW_U_IMM};
			4'hE: mode = '{tw_pkg::TW_K_FAST,   tw_pkg::TW_T_CAPV,  tw_pkg::TW_U_TOP};
			4'hF: mode = '{tw_pkg::TW_K_FAST,   tw_pkg::TW_T_CMPA,  tw_pkg::TW_U_TOP};
			default: mode = '{tw_pkg::TW_K_RSVD, tw_pkg::TW_T_MAX,  tw_pkg::TW_U_IMM};
		endcase
	end

	logic [15:0] top_val;

	always_comb begin
		case (mode.top_src)
			tw_pkg::TW_T_8BIT:  top_val = `TW_TOP_8BIT;
			tw_pkg::TW_T_9BIT:  top_val = `TW_TOP_9BIT;
			tw_pkg::TW_T_10BIT: top_val = `TW_TOP_10BIT;
			tw_pkg::TW_T_CMPA:  top_val = compare_value_a;
			tw_pkg::TW_T_CAPV:  top_val = capture_value_reg;
			default:            top_val = `TW_TOP_MAX;
		endcase
	end

	wire is_non_pwm = (mode.kind == tw_pkg::TW_K_NORMAL) || (mode.kind == tw_pkg::TW_K_CTC);
	wire is_dual    = (mode.kind == tw_pkg::TW_K_PHASE) || (mode.kind == tw_pkg::TW_K_PFC);
	wire is_fast    = (mode.kind == tw_pkg::TW_K_FAST);
	wire running    = (mode.kind != tw_pkg::TW_K_RSVD);

	// Bus strobes
	wire wr_force  = io_wr && (io_addr == `TW_OFS_FORCE);
	wire wr_capclk = io_wr && (io_addr == `TW_OFS_CAP_CLK);
	wire wr_act    = io_wr && (io_addr == `TW_OFS_ACT_MODE);
	wire wr_flags  = io_wr && (io_addr == `TW_OFS_FLAGS);
	wire wr_high   = io_wr && ((io_addr == `TW_OFS_CNT_H) || (io_addr == `TW_OFS_CMPA_H)
		|| (io_addr == `TW_OFS_CMPB_H) || (io_addr == `TW_OFS_CAPV_H));
	wire wr_cnt    = io_wr && (io_addr == `TW_OFS_CNT_L);
	wire wr_cmpa   = io_wr && (io_addr == `TW_OFS_CMPA_L);
	wire wr_cmpb   = io_wr && (io_addr == `TW_OFS_CMPB_L);
	wire wr_capv   = io_wr && (io_addr == `TW_OFS_CAPV_L);
	wire rd_cnt_l  = io_rd && (io_addr == `TW_OFS_CNT_L);
	wire rd_capv_l = io_rd && (io_addr == `TW_OFS_CAPV_L);
	wire [15:0] wr_word = {temp_high, io_wdata};

	// Count enable: prescaler taps or synchronised external edges
	wire ext_rise = ext_sync[1] && !ext_prev;
	wire ext_fall = !ext_sync[1] && ext_prev;
	logic tick;

	always_comb begin
		case (count_clock_select)
			3'b001:  tick = 1'b1;
			3'b010:  tick = (presc[2:0] == 3'(`TW_DIV8_END));
			3'b011:  tick = (presc[5:0] == 6'(`TW_DIV64_END));
			3'b100:  tick = (presc[7:0] == 8'(`TW_DIV256_END));
			3'b101:  tick = (presc == PRESC_W'(`TW_DIV1024_END));
			3'b110:  tick = ext_fall;
			3'b111:  tick = ext_rise;
			default: tick = 1'b0;
		endcase
	end

	wire step    = tick && running && !wr_cnt;
	wire at_top  = (counter_value == top_val);
	wire at_bot  = (counter_value == 16'h0000);
	wire at_max  = (counter_value == `TW_TOP_MAX);
	wire wrap    = step && at_top && (is_fast || mode.kind == tw_pkg::TW_K_CTC);
	wire bottom_turn = step && at_bot && !count_up && is_dual;
	wire top_turn    = step && at_top && count_up && is_dual;

	// Overflow point per mode
	logic ovf_evt;

	always_comb begin
		case (mode.kind)
			tw_pkg::TW_K_NORMAL: ovf_evt = step && at_max;
			tw_pkg::TW_K_CTC:    ovf_evt = step && at_max;
			tw_pkg::TW_K_FAST:   ovf_evt = step && at_top;
			tw_pkg::TW_K_PHASE:  ovf_evt = bottom_turn;
			tw_pkg::TW_K_PFC:    ovf_evt = bottom_turn;
			default:             ovf_evt = 1'b0;
		endcase
	end

	// Compare buffer load point
	wire load_cmp = (mode.upd_at == tw_pkg::TW_U_IMM)
		|| ((mode.upd_at == tw_pkg::TW_U_TOP) && step && at_top)
		|| ((mode.upd_at == tw_pkg::TW_U_BOTTOM) && step && at_bot);

	// Next counter value and direction
	logic [15:0] next_counter;
	logic        next_up;

	always_comb begin
		next_counter = counter_value;
		next_up      = count_up;
		if (wr_cnt) begin
			next_counter = wr_word;
		end else if (step) begin
			if (is_dual) begin
				if (count_up && at_top) begin
					next_up      = 1'b0;
					next_counter = counter_value - 16'h0001;
				end else if (!count_up && at_bot) begin
					next_up      = 1'b1;
					next_counter = counter_value + 16'h0001;
				end else if (count_up) begin
					next_counter = counter_value + 16'h0001;
				end else begin
					next_counter = counter_value - 16'h0001;
				end
			end else if (wrap) begin
				next_counter = 16'h0000;
			end else begin
				next_counter = counter_value + 16'h0001;
			end
		end
	end

	// Compare matches; a counter write masks the next timer clock
	wire match_a = step && !match_blocked && (counter_value == compare_value_a);
	wire match_b = step && !match_blocked && (counter_value == compare_value_b);
	wire force_a = wr_force && io_wdata[`TW_FORCE_A_BIT] && is_non_pwm;
	wire force_b = wr_force && io_wdata[`TW_FORCE_B_BIT] && is_non_pwm;

	// Next level of one wave output; all mode state comes in as arguments so the
	// continuous assignments below re-evaluate on every change of it
	function automatic logic wave_next(input logic cur, input logic [1:0] act,
		input logic hit, input logic frc, input logic cmp_is_top, input logic is_a,
		input logic non_pwm, input logic fast, input logic dual, input logic top_bit,
		input logic wrap_now, input logic up);
		logic nxt;
		nxt = cur;
		if (non_pwm) begin
			if (hit || frc) begin
				case (act)
					2'b01:   nxt = !cur;
					2'b10:   nxt = 1'b0;
					2'b11:   nxt = 1'b1;
					default: nxt = cur;
				endcase
			end
		end else if (act == 2'b01) begin
			if (top_bit && is_a && hit)
				nxt = !cur;
		end else if (act[1] && fast) begin
			if (hit && !cmp_is_top)
				nxt = act[0];
			else if (wrap_now)
				nxt = !act[0];
		end else if (act[1] && dual && hit) begin
			nxt = up ? act[0] : !act[0];
		end
		return nxt;
	endfunction

	wire next_level_a = wave_next(level_a, chan_a_output_action, match_a, force_a,
		compare_value_a == top_val, 1'b1, is_non_pwm, is_fast, is_dual,
		waveform_mode_top_bit, wrap, count_up);
	wire next_level_b = wave_next(level_b, chan_b_output_action, match_b, force_b,
		compare_value_b == top_val, 1'b0, is_non_pwm, is_fast, is_dual,
		waveform_mode_top_bit, wrap, count_up);

	// Capture path: two-stage sync, optional filter, edge select
	wire cap_disabled = (mode.top_src == tw_pkg::TW_T_CAPV);
	wire cap_all_eq   = (cap_hist == 4'hF) || (cap_hist == 4'h0);
	wire cap_level    = capture_filter_enable ? cap_filt : cap_sync[1];
	wire cap_edge     = capture_edge_select ? (cap_level && !cap_prev)
		: (!cap_level && cap_prev);
	wire capture_evt  = cap_edge && !cap_disabled;
	wire cap_flag_set = capture_evt || (cap_disabled && step && at_top);

	// Flags: hardware set wins over a write-one clear; forces never set them
	wire [7:0] flag_set = {2'b00, cap_flag_set, 2'b00, match_b, match_a, ovf_evt};
	wire [7:0] flag_clr = wr_flags ? io_wdata : 8'h00;
	wire [7:0] next_flags = ((flags & ~flag_clr) | flag_set) & 8'h27;

	// Read mux
	always_comb begin
		case (io_addr)
			`TW_OFS_ACT_MODE: rdata = output_action_mode_control;
			`TW_OFS_CAP_CLK:  rdata = capture_mode_clock_control;
			`TW_OFS_FORCE:    rdata = 8'h00;
			`TW_OFS_FLAGS:    rdata = flags;
			`TW_OFS_CNT_L:    rdata = counter_value[7:0];
			`TW_OFS_CNT_H:    rdata = temp_high;
			`TW_OFS_CAPV_L:   rdata = capture_value_reg[7:0];
			`TW_OFS_CAPV_H:   rdata = temp_high;
			`TW_OFS_CMPA_L:   rdata = cmp_buf_a[7:0];
			`TW_OFS_CMPA_H:   rdata = cmp_buf_a[15:8];
			`TW_OFS_CMPB_L:   rdata = cmp_buf_b[7:0];
			`TW_OFS_CMPB_H:   rdata = cmp_buf_b[15:8];
			default:          rdata = 8'h00;
		endcase
	end

	// Control and bus registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			output_action_mode_control <= `TW_RST_ACT_MODE;
			capture_mode_clock_control <= `TW_RST_CAP_CLK;
			flags                      <= 8'h00;
			temp_high                  <= 8'h00;
			io_rdata                   <= 8'h00;
		end else begin
			if (wr_act)
				output_action_mode_control <= io_wdata;
			if (wr_capclk)
				capture_mode_clock_control <= io_wdata & `TW_CAP_CLK_MASK;
			flags <= next_flags;
			if (wr_high)
				temp_high <= io_wdata;
			else if (rd_cnt_l)
				temp_high <= counter_value[15:8];
			else if (rd_capv_l)
				temp_high <= capture_value_reg[15:8];
			if (io_rd)
				io_rdata <= rdata;
		end
	end

	// Counter, compare and capture registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			counter_value     <= `TW_RST_WORD;
			count_up          <= 1'b1;
			match_blocked     <= 1'b0;
			cmp_buf_a         <= `TW_RST_WORD;
			cmp_buf_b         <= `TW_RST_WORD;
			compare_value_a   <= `TW_RST_WORD;
			compare_value_b   <= `TW_RST_WORD;
			capture_value_reg <= `TW_RST_WORD;
		end else begin
			counter_value <= next_counter;
			count_up      <= next_up;
			if (wr_cnt)
				match_blocked <= 1'b1;
			else if (tick)
				match_blocked <= 1'b0;
			if (wr_cmpa)
				cmp_buf_a <= wr_word;
			if (wr_cmpb)
				cmp_buf_b <= wr_word;
			if (load_cmp) begin
				compare_value_a <= cmp_buf_a;
				compare_value_b <= cmp_buf_b;
			end
			if (wr_capv)
				capture_value_reg <= wr_word;
			else if (capture_evt)
				capture_value_reg <= counter_value;
		end
	end

	// Pin sampling, prescaler and wave levels
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			presc    <= '0;
			ext_sync <= 2'b00;
			ext_prev <= 1'b0;
			cap_sync <= 2'b00;
			cap_hist <= 4'h0;
			cap_filt <= 1'b0;
			cap_prev <= 1'b0;
			level_a  <= 1'b0;
			level_b  <= 1'b0;
		end else begin
			presc    <= presc + 1'b1;
			ext_sync <= {ext_sync[0], external_count_pin};
			ext_prev <= ext_sync[1];
			cap_sync <= {cap_sync[0], capture_input_pin};
			cap_hist <= {cap_hist[2:0], cap_sync[1]};
			if (cap_all_eq)
				cap_filt <= cap_hist[3];
			cap_prev <= cap_level;
			level_a  <= next_level_a;
			level_b  <= next_level_b;
		end
	end

	// Pin override and drive
	assign wave_out_a.level    = level_a;
	assign wave_out_a.override = (chan_a_output_action != 2'b00);
	assign wave_out_a.drive_en = wave_out_a.override && dir_out_a;
	assign wave_out_b.level    = level_b;
	assign wave_out_b.override = (chan_b_output_action != 2'b00);
	assign wave_out_b.drive_en = wave_out_b.override && dir_out_b;
	assign event_flags         = flags;

endmodule // tw_timer16

// file: tw_defs.svh
// Offsets, field positions, reset values and fixed counts of the 16-bit timer
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

// Register offsets on the 6-bit I/O address bus
`define TW_OFS_FORCE      6'h22
`define TW_OFS_CAP_CLK    6'h2E
`define TW_OFS_ACT_MODE   6'h2F
`define TW_OFS_CNT_L      6'h2C
`define TW_OFS_CNT_H      6'h2D
`define TW_OFS_CMPA_L     6'h2A
`define TW_OFS_CMPA_H     6'h2B
`define TW_OFS_CMPB_L     6'h28
`define TW_OFS_CMPB_H     6'h29
`define TW_OFS_CAPV_L     6'h24
`define TW_OFS_CAPV_H     6'h25
`define TW_OFS_FLAGS      6'h0B

// Field positions
`define TW_ACT_A_HI       7
`define TW_ACT_A_LO       6
`define TW_ACT_B_HI       5
`define TW_ACT_B_LO       4
`define TW_WGM_LO_HI      1
`define TW_WGM_LO_LO      0
`define TW_FILT_EN_BIT    7
`define TW_EDGE_SEL_BIT   6
`define TW_RSVD_B_BIT     5
`define TW_WGM_HI_HI      4
`define TW_WGM_HI_LO      3
`define TW_CS_HI          2
`define TW_CS_LO          0
`define TW_FORCE_A_BIT    7
`define TW_FORCE_B_BIT    6
`define TW_FLG_CAP_BIT    5
`define TW_FLG_CMPB_BIT   2
`define TW_FLG_CMPA_BIT   1
`define TW_FLG_OVF_BIT    0

// Reset values and writable masks
`define TW_RST_ACT_MODE   8'h00
`define TW_RST_CAP_CLK    8'h00
`define TW_CAP_CLK_MASK   8'hDF
`define TW_RST_WORD       16'h0000

// Fixed TOP values
`define TW_TOP_MAX        16'hFFFF
`define TW_TOP_8BIT       16'h00FF
`define TW_TOP_9BIT       16'h01FF
`define TW_TOP_10BIT      16'h03FF

// Prescaler terminal counts for divide by 8, 64, 256 and 1024
`define TW_DIV8_END       10'h007
`define TW_DIV64_END      10'h03F
`define TW_DIV256_END     10'h0FF
`define TW_DIV1024_END    10'h3FF

// Equal samples needed by the capture filter
`define TW_FILT_SAMPLES   4

`endif

// file: tw_pkg.sv
// Types shared by the 16-bit timer control logic
package tw_pkg;

	typedef enum logic [2:0] {
		TW_K_NORMAL = 3'b000,
		TW_K_CTC    = 3'b001,
		TW_K_FAST   = 3'b010,
		TW_K_PHASE  = 3'b011,
		TW_K_PFC    = 3'b100,
		TW_K_RSVD   = 3'b101
	} tw_kind_t;

	typedef enum logic [2:0] {
		TW_T_MAX   = 3'b000,
		TW_T_8BIT  = 3'b001,
		TW_T_9BIT  = 3'b010,
		TW_T_10BIT = 3'b011,
		TW_T_CMPA  = 3'b100,
		TW_T_CAPV  = 3'b101
	} tw_top_t;

	typedef enum logic [1:0] {
		TW_U_IMM    = 2'b00,
		TW_U_TOP    = 2'b01,
		TW_U_BOTTOM = 2'b10
	} tw_upd_t;

	typedef struct packed {
		tw_kind_t kind;
		tw_top_t  top_src;
		tw_upd_t  upd_at;
	} tw_mode_t;

	typedef struct packed {
		logic level;
		logic drive_en;
		logic override;
	} tw_pin_t;

endpackage

// file: tw_timer16_monitor.sv
// Port checker for the 16-bit timer control block, bound to its top
`timescale 1ns/1ps
`include "tw_defs.svh"
module tw_timer16_monitor (
	// Clock and reset
	input wire logic            clock,
	input wire logic            sys_rst,
	// Register port
	input wire logic [5:0]      io_addr,
	input wire logic            io_wr,
	input wire logic            io_rd,
	input wire logic [7:0]      io_wdata,
	input wire logic [7:0]      io_rdata,
	// Pins and flags
	input wire logic            dir_out_a,
	input wire logic            dir_out_b,
	input wire logic            capture_input_pin,
	input wire logic            external_count_pin,
	input wire tw_pkg::tw_pin_t wave_out_a,
	input wire tw_pkg::tw_pin_t wave_out_b,
	input wire logic [7:0]      event_flags
);
	logic [7:0] ctl_a;
	logic [7:0] ctl_b;

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	// Shadow of the two control registers as software last wrote them
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctl_a <= 8'h00;
			ctl_b <= 8'h00;
		end else if (io_wr && io_addr == `TW_OFS_ACT_MODE) begin
			ctl_a <= io_wdata;
		end else if (io_wr && io_addr == `TW_OFS_CAP_CLK) begin
			ctl_b <= io_wdata & 8'hDF;
		end
	end

	a_drive_dir_a: assert property (wave_out_a.drive_en
		== ((ctl_a[7:6] != 2'b00) && dir_out_a))
		else $error("wave a drive enable wrong");
	a_drive_dir_b: assert property (wave_out_b.drive_en
		== ((ctl_a[5:4] != 2'b00) && dir_out_b))
		else $error("wave b drive enable wrong");
	a_override_a: assert property (wave_out_a.override == (ctl_a[7:6] != 2'b00))
		else $error("wave a override wrong");
	a_override_b: assert property (wave_out_b.override == (ctl_a[5:4] != 2'b00))
		else $error("wave b override wrong");
	a_ctrl_a_read: assert property (io_rd && io_addr == `TW_OFS_ACT_MODE
		|=> io_rdata == $past(ctl_a))
		else $error("control a readback wrong");
	a_ctrl_b_read: assert property (io_rd && io_addr == `TW_OFS_CAP_CLK
		|=> io_rdata == $past(ctl_b))
		else $error("control b readback wrong");
	a_force_reads_zero: assert property (io_rd && io_addr == `TW_OFS_FORCE
		|=> io_rdata == 8'h00)
		else $error("force register reads nonzero");
	a_spare_flags_zero: assert property (event_flags[7:6] == 2'b00 && event_flags[4:3] == 2'b00)
		else $error("spare flag bits set");
endmodule // tw_timer16_monitor

bind tw_timer16 tw_timer16_monitor u_mon (
	.clock(clock), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
	.io_wdata(io_wdata), .io_rdata(io_rdata), .dir_out_a(dir_out_a), .dir_out_b(dir_out_b),
	.capture_input_pin(capture_input_pin), .external_count_pin(external_count_pin),
	.wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .event_flags(event_flags)
);

// file: tw_timer16_test.sv
// Self-checking bench for the 16-bit timer control block
`timescale 1ns/1ps
`include "tw_defs.svh"
module tw_timer16_test;
	logic            clock = 1'b0;
	logic            sys_rst = 1'b1;
	logic [5:0]      io_addr = 6'h00;
	logic            io_wr = 1'b0;
	logic            io_rd = 1'b0;
	logic [7:0]      io_wdata = 8'h00;
	logic [7:0]      io_rdata;
	logic            dir_a = 1'b0;
	logic            dir_b = 1'b0;
	logic            cap_pin = 1'b0;
	logic            ext_pin = 1'b0;
	tw_pkg::tw_pin_t wa;
	tw_pkg::tw_pin_t wb;
	logic [7:0]      flags;
	logic [15:0]     rnd = 16'h2BD1;
	logic [15:0]     v;
	logic [7:0]      d;
	logic            la;
	logic            lb;
	logic [7:0]      wq[$];
	logic [5:0]      ctl[4] = '{`TW_OFS_CAP_CLK, `TW_OFS_ACT_MODE, `TW_OFS_FORCE, `TW_OFS_FLAGS};
	int              fail_count = 0;
	int              compares = 0;

	always #25 clock = ~clock;

	tw_timer16 dut (.clock(clock), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .dir_out_a(dir_a),
		.dir_out_b(dir_b), .capture_input_pin(cap_pin), .external_count_pin(ext_pin),
		.wave_out_a(wa), .wave_out_b(wb), .event_flags(flags));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic final_report();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] dat);
		@(negedge clock);
		io_addr = a;
		io_wdata = dat;
		io_wr = 1'b1;
		@(negedge clock);
		io_wr = 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] dat);
		@(negedge clock);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clock);
		io_rd = 1'b0;
		dat = io_rdata;
	endtask

	// High byte goes through the shared temporary byte first
	task automatic wr16(input logic [5:0] a, input logic [15:0] val);
		wr(a + 6'h01, val[15:8]);
		wr(a, val[7:0]);
	endtask

	task automatic rd16(input logic [5:0] a, output logic [15:0] val);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(a, lo);
		rd(a + 6'h01, hi);
		val = {hi, lo};
	endtask

	task automatic wait_flag(input int b);
		int n;
		n = 0;
		while (flags[b] !== 1'b1 && n < 3000) begin
			@(negedge clock);
			n++;
		end
		if (n == 3000) begin
			fail_count++;
			$display("ERROR flag wait expected 1 seen 0");
			final_report();
		end
	endtask

	initial begin
		cyc(8);
		sys_rst = 1'b0;
		foreach (ctl[i]) begin
			rd(ctl[i], d);
			chk("reset value", d, 16'h0000);
		end
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			dir_a = rnd[8];
			dir_b = rnd[9];
			wr(`TW_OFS_ACT_MODE, rnd[7:0] & 8'hFC);
			wq.push_back(rnd[7:0] & 8'hFC);
			chk("drive a", wa.drive_en, 16'(rnd[7:6] != 2'b00 && rnd[8]));
			chk("drive b", wb.drive_en, 16'(rnd[5:4] != 2'b00 && rnd[9]));
			rd(`TW_OFS_ACT_MODE, d);
			chk("control a", d, wq.pop_front());
		end
		wr(`TW_OFS_CAP_CLK, 8'hFF);
		rd(`TW_OFS_CAP_CLK, d);
		chk("control b", d, 16'h00DF);
		wr(`TW_OFS_CAP_CLK, 8'h00);
		wr16(`TW_OFS_CNT_L, 16'h01FF);
		rd16(`TW_OFS_CNT_L, v);
		chk("counter", v, 16'h01FF);
		wr(`TW_OFS_CMPA_H, 8'h12);
		wr(`TW_OFS_CMPA_L, 8'h34);
		wr(`TW_OFS_CMPB_L, 8'h56);
		rd16(`TW_OFS_CMPA_L, v);
		chk("compare a", v, 16'h1234);
		rd(`TW_OFS_CNT_L, d);
		rd(`TW_OFS_CMPB_H, d);
		chk("compare b high", d, 16'h0012);
		// Toggle on match, then overflow at MAX
		wr(`TW_OFS_ACT_MODE, 8'h40);
		wr16(`TW_OFS_CMPA_L, 16'hFFF8);
		wr16(`TW_OFS_CNT_L, 16'hFFF0);
		wr(`TW_OFS_FLAGS, 8'hFF);
		wr(`TW_OFS_CAP_CLK, 8'h01);
		wait_flag(1);
		cyc(3);
		chk("toggle a", wa.level, 16'h0001);
		wait_flag(0);
		wr(`TW_OFS_CAP_CLK, 8'h00);
		chk("flags", flags[1:0], 16'h0003);
		rd16(`TW_OFS_CNT_L, v);
		chk("wrapped", v[15:8], 16'h0000);
		// Forced matches through action codes 01, 10 and 11
		wr(`TW_OFS_FLAGS, 8'hFF);
		la = 1'b1;
		lb = wb.level;
		for (int c = 1; c < 4; c++) begin
			wr(`TW_OFS_ACT_MODE, {c[1:0], c[1:0], 4'h0});
			wr(`TW_OFS_FORCE, 8'hC0);
			cyc(2);
			la = (c == 1) ? ~la : c[0];
			lb = (c == 1) ? ~lb : c[0];
			chk("force a", wa.level, la);
			chk("force b", wb.level, lb);
			chk("force flags", flags, 16'h0000);
			rd(`TW_OFS_FORCE, d);
			chk("force read", d, 16'h0000);
		end
		// Fast PWM 8-bit: force ignored; A non-inverting, B inverting
		wr(`TW_OFS_CAP_CLK, 8'h08);
		wr(`TW_OFS_ACT_MODE, 8'hB1);
		wr(`TW_OFS_FORCE, 8'hC0);
		cyc(2);
		chk("pwm force", {wa.level, wb.level}, 16'h0003);
		wr16(`TW_OFS_CMPA_L, 16'h0010);
		wr16(`TW_OFS_CNT_L, 16'h00F0);
		wr(`TW_OFS_FLAGS, 8'hFF);
		wr(`TW_OFS_CAP_CLK, 8'h09);
		wait_flag(0);
		wait_flag(1);
		cyc(3);
		wr(`TW_OFS_CAP_CLK, 8'h08);
		chk("pwm a", wa.level, 16'h0000);
		chk("pwm b", wb.level, 16'h0000);
		// Capture on the selected edge only, filtered and disabled cases
		wr(`TW_OFS_ACT_MODE, 8'h00);
		wr(`TW_OFS_CAP_CLK, 8'h40);
		wr16(`TW_OFS_CNT_L, 16'h1234);
		wr(`TW_OFS_FLAGS, 8'hFF);
		cap_pin = 1'b1;
		wait_flag(5);
		rd16(`TW_OFS_CAPV_L, v);
		chk("capture", v, 16'h1234);
		wr(`TW_OFS_FLAGS, 8'hFF);
		cap_pin = 1'b0;
		cyc(10);
		chk("wrong edge", flags[5], 16'h0000);
		wr(`TW_OFS_CAP_CLK, 8'hC0);
		cap_pin = 1'b1;
		cyc(2);
		cap_pin = 1'b0;
		cyc(12);
		chk("filtered", flags[5], 16'h0000);
		cap_pin = 1'b1;
		wait_flag(5);
		wr(`TW_OFS_CAP_CLK, 8'h18);
		wr(`TW_OFS_FLAGS, 8'hFF);
		cap_pin = 1'b0;
		cyc(12);
		chk("capture off", flags[5], 16'h0000);
		// External pin edges, rising then falling
		wr(`TW_OFS_CAP_CLK, 8'h07);
		wr16(`TW_OFS_CNT_L, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			if (i == 3)
				wr(`TW_OFS_CAP_CLK, 8'h06);
			ext_pin = 1'b1;
			cyc(5);
			ext_pin = 1'b0;
			cyc(5);
		end
		wr(`TW_OFS_CAP_CLK, 8'h00);
		rd16(`TW_OFS_CNT_L, v);
		chk("external", v, 16'h0006);
		// Reserved mode keeps the counter still
		wr16(`TW_OFS_CNT_L, 16'h0100);
		wr(`TW_OFS_ACT_MODE, 8'h01);
		wr(`TW_OFS_CAP_CLK, 8'h19);
		cyc(20);
		wr(`TW_OFS_CAP_CLK, 8'h18);
		rd16(`TW_OFS_CNT_L, v);
		chk("reserved mode", v, 16'h0100);
		// Phase correct 8-bit: set on down match, overflow at BOTTOM, clear on up match
		wr(`TW_OFS_ACT_MODE, 8'h81);
		wr16(`TW_OFS_CNT_L, 16'h0020);
		wr(`TW_OFS_FLAGS, 8'hFF);
		wr(`TW_OFS_CAP_CLK, 8'h01);
		wait_flag(0);
		chk("bottom overflow", flags[1:0], 16'h0003);
		chk("down match", wa.level, 16'h0001);
		wr(`TW_OFS_FLAGS, 8'hFF);
		wait_flag(1);
		chk("up match", wa.level, 16'h0000);
		wr(`TW_OFS_CAP_CLK, 8'h00);
		final_report();
	end
endmodule // tw_timer16_test
